//--- verilog/prs_sequencer.sv
// Display and touch reset sequencer of the panel module
`timescale 1ns/1ps
`include "prs_cfg.svh"

// Function
// - Low glitches under 5 us ignored
// - High spikes inside reset also ignored
// - Blank during reset; blanking sequence up to 120 ms, ended by release, if awake at a reset from run
// - Hardware reset restores default configuration
// - Load OTP within 5 ms after release
// - Touch reset 100 ns; loader 11, reboot 16 ms
module prs_sequencer
    import prs_pkg::*;
#(
    parameter int GLITCH_CYC       = `PRS_GLITCH_CYC,
    parameter int PULSE_MIN_CYC    = `PRS_PULSE_MIN_CYC,
    parameter int BLANK_CYC        = `PRS_BLANK_CYC,
    parameter int LOAD_CYC         = `PRS_LOAD_CYC,
    parameter int WAKE_CYC         = `PRS_WAKE_CYC,
    parameter int TOUCH_PULSE_CYC  = `PRS_TOUCH_PULSE_CYC,
    parameter int TOUCH_LOADER_CYC = `PRS_TOUCH_LOADER_CYC,
    parameter int TOUCH_REBOOT_CYC = `PRS_TOUCH_REBOOT_CYC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Reset pins from the host
    input  wire logic panel_reset_n,
    input  wire logic touch_reset_n,
    // Display state
    input  wire logic awake,
    output logic      blank_reg,
    output logic      blank_seq_reg,
    output logic      config_default_reg,
    output logic      otp_load_reg,
    output logic      cmd_ready_reg,
    output logic      wake_ready_reg,
    // Touch state
    output logic      touch_loader_active_reg,
    output logic      touch_ready_reg
);

    localparam int CW = 32;

    // ========================================
    // Display reset filter
    logic          filt_level_reg;
    logic [CW-1:0] glitch_cnt_reg;
    logic [CW-1:0] low_cnt_reg;
    logic          fall_evt;
    logic          rise_evt;

    // A level change counts only after it holds for the glitch time, both ways
    always_ff @(posedge core_clk) begin
        if (srst) begin
            filt_level_reg <= 1'b1;
            glitch_cnt_reg <= '0;
        end else if (panel_reset_n == filt_level_reg) begin
            glitch_cnt_reg <= '0;
        end else if (glitch_cnt_reg >= CW'(GLITCH_CYC - 1)) begin
            filt_level_reg <= panel_reset_n;
            glitch_cnt_reg <= '0;
        end else begin
            glitch_cnt_reg <= glitch_cnt_reg + 1'b1;
        end
    end

    assign fall_evt = filt_level_reg && !panel_reset_n && glitch_cnt_reg >= CW'(GLITCH_CYC - 1);
    assign rise_evt = !filt_level_reg && panel_reset_n && glitch_cnt_reg >= CW'(GLITCH_CYC - 1);

    // ========================================
    // Display sequence
    prs_disp_state_t disp_state_reg;
    logic [CW-1:0]   disp_cnt_reg;
    logic [CW-1:0]   since_rise_reg;
    logic            was_awake_reg;

    // Pulse width counted from the raw fall: loaded with the glitch time at the filtered fall
    always_ff @(posedge core_clk) begin
        if (srst) begin
            low_cnt_reg <= '0;
        end else if (fall_evt) begin
            low_cnt_reg <= CW'(GLITCH_CYC);
        end else if (!filt_level_reg && low_cnt_reg != '1) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    // Short pulses (5 to 15 us) still run the full initialisation: safest reading
    always_ff @(posedge core_clk) begin
        if (srst) begin
            disp_state_reg <= PRS_RUN;
            disp_cnt_reg   <= '0;
            was_awake_reg  <= 1'b0;
        end else begin
            case (disp_state_reg)
                PRS_RUN: begin
                    if (fall_evt) begin
                        disp_state_reg <= PRS_RESET;
                        was_awake_reg  <= awake;
                        disp_cnt_reg   <= '0;
                    end
                end
                PRS_RESET: begin
                    if (disp_cnt_reg != '1) begin
                        disp_cnt_reg <= disp_cnt_reg + 1'b1;
                    end
                    if (rise_evt) begin
                        disp_state_reg <= PRS_LOAD;
                        disp_cnt_reg   <= '0;
                    end
                end
                PRS_LOAD: begin
                    disp_cnt_reg <= disp_cnt_reg + 1'b1;
                    if (fall_evt) begin
                        disp_state_reg <= PRS_RESET;
                        was_awake_reg  <= 1'b0;
                        disp_cnt_reg   <= '0;
                    end else if (disp_cnt_reg >= CW'(LOAD_CYC - 1)) begin
                        disp_state_reg <= PRS_RUN;
                    end
                end
                default: disp_state_reg <= PRS_RUN;
            endcase
        end
    end

    // Outputs of the display side
    always_ff @(posedge core_clk) begin
        if (srst) begin
            blank_reg          <= 1'b1;
            blank_seq_reg      <= 1'b0;
            config_default_reg <= 1'b1;
            otp_load_reg       <= 1'b0;
        end else begin
            blank_reg     <= disp_state_reg != PRS_RUN || fall_evt;
            blank_seq_reg <= disp_state_reg == PRS_RESET && was_awake_reg
                             && disp_cnt_reg < CW'(BLANK_CYC);
            if (disp_state_reg == PRS_RESET) begin
                config_default_reg <= 1'b1;
            end else if (disp_state_reg == PRS_LOAD) begin
                config_default_reg <= 1'b0;
            end
            otp_load_reg <= disp_state_reg == PRS_LOAD;
        end
    end

    // Command and wake gates from the filtered release
    always_ff @(posedge core_clk) begin
        if (srst) begin
            since_rise_reg <= '0;
            cmd_ready_reg  <= 1'b0;
            wake_ready_reg <= 1'b0;
        end else if (!filt_level_reg || rise_evt) begin
            since_rise_reg <= '0;
            cmd_ready_reg  <= 1'b0;
            wake_ready_reg <= 1'b0;
        end else begin
            if (since_rise_reg != '1) begin
                since_rise_reg <= since_rise_reg + 1'b1;
            end
            cmd_ready_reg  <= disp_state_reg == PRS_RUN;
            wake_ready_reg <= since_rise_reg >= CW'(WAKE_CYC - 1);
        end
    end

    // ========================================
    // Touch reset and reboot
    prs_touch_state_t touch_state_reg;
    logic [CW-1:0]    touch_cnt_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            touch_state_reg         <= PRS_T_RUN;
            touch_cnt_reg           <= '0;
            touch_loader_active_reg <= 1'b0;
            touch_ready_reg         <= 1'b0;
        end else begin
            case (touch_state_reg)
                PRS_T_RUN: begin
                    touch_ready_reg <= 1'b1;
                    touch_cnt_reg   <= '0;
                    if (!touch_reset_n) begin
                        touch_state_reg <= PRS_T_RESET;
                        touch_ready_reg <= 1'b0;
                        touch_cnt_reg   <= CW'(1);
                    end
                end
                PRS_T_RESET: begin
                    touch_loader_active_reg <= 1'b0;
                    touch_ready_reg         <= 1'b0;
                    if (!touch_reset_n) begin
                        if (touch_cnt_reg != '1) begin
                            touch_cnt_reg <= touch_cnt_reg + 1'b1;
                        end
                    end else if (touch_cnt_reg >= CW'(TOUCH_PULSE_CYC)) begin
                        touch_state_reg <= PRS_T_BOOT;
                        touch_cnt_reg   <= '0;
                    end else begin
                        touch_state_reg <= PRS_T_RUN;
                    end
                end
                PRS_T_BOOT: begin
                    touch_cnt_reg <= touch_cnt_reg + 1'b1;
                    if (touch_cnt_reg == CW'(TOUCH_LOADER_CYC - 1)) begin
                        touch_loader_active_reg <= 1'b1;
                    end
                    if (!touch_reset_n) begin
                        touch_state_reg <= PRS_T_RESET;
                        touch_cnt_reg   <= CW'(1);
                    end else if (touch_cnt_reg >= CW'(TOUCH_REBOOT_CYC - 1)) begin
                        touch_state_reg         <= PRS_T_RUN;
                        touch_loader_active_reg <= 1'b0;
                    end
                end
                default: touch_state_reg <= PRS_T_RUN;
            endcase
        end
    end

endmodule // prs_sequencer

//--- verilog/prs_cfg.svh
// Timing constants for the panel reset sequencer
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

`define PRS_CLK_MHZ            50
// Times in their own units
`define PRS_GLITCH_US          5
`define PRS_PULSE_MIN_US       15
`define PRS_BLANK_MS           120
`define PRS_LOAD_MS            5
`define PRS_CMD_WAIT_MS        5
`define PRS_WAKE_WAIT_MS       120
`define PRS_TOUCH_PULSE_NS     100
`define PRS_TOUCH_LOADER_MS    11
`define PRS_TOUCH_REBOOT_MS    16
// Cycle counts derived from the clock rate
`define PRS_GLITCH_CYC         (`PRS_GLITCH_US * `PRS_CLK_MHZ)
`define PRS_PULSE_MIN_CYC      (`PRS_PULSE_MIN_US * `PRS_CLK_MHZ)
`define PRS_BLANK_CYC          (`PRS_BLANK_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_LOAD_CYC           (`PRS_LOAD_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_WAKE_CYC           (`PRS_WAKE_WAIT_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_TOUCH_PULSE_CYC    ((`PRS_TOUCH_PULSE_NS * `PRS_CLK_MHZ + 999) / 1000)
`define PRS_TOUCH_LOADER_CYC   (`PRS_TOUCH_LOADER_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_TOUCH_REBOOT_CYC   (`PRS_TOUCH_REBOOT_MS * 1000 * `PRS_CLK_MHZ)

`endif

//--- verilog/prs_pkg.sv
// Types for the panel reset sequencer
package prs_pkg;
    typedef enum logic [2:0] {
        PRS_RUN,
        PRS_RESET,
        PRS_LOAD
    } prs_disp_state_t;

    typedef enum logic [1:0] {
        PRS_T_RESET,
        PRS_T_BOOT,
        PRS_T_RUN
    } prs_touch_state_t;
endpackage

//--- sim/prs_sequencer_sva.sv
// Assertion checker for the panel reset sequencer
`timescale 1ns/1ps
module prs_sequencer_sva #(
    parameter int LOAD_CYC         = 20,
    parameter int BLANK_CYC        = 50,
    parameter int TOUCH_LOADER_CYC = 30,
    parameter int TOUCH_REBOOT_CYC = 40
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic panel_reset_n,
    input wire logic touch_reset_n,
    input wire logic blank_reg,
    input wire logic blank_seq_reg,
    input wire logic config_default_reg,
    input wire logic otp_load_reg,
    input wire logic cmd_ready_reg,
    input wire logic wake_ready_reg,
    input wire logic touch_loader_active_reg,
    input wire logic touch_ready_reg
);
    // ==========
    // Run counters
    logic [15:0] otp_cnt_reg;
    logic [15:0] seq_cnt_reg;
    logic [15:0] tch_cnt_reg;
    always_ff @(posedge core_clk) otp_cnt_reg <= otp_load_reg ? otp_cnt_reg + 16'h1 : 16'h0;
    always_ff @(posedge core_clk) seq_cnt_reg <= blank_seq_reg ? seq_cnt_reg + 16'h1 : 16'h0;
    // Saturates so a long idle touch line never wraps back into range
    always_ff @(posedge core_clk) begin
        if (srst || !touch_reset_n) tch_cnt_reg <= 16'h0;
        else if (tch_cnt_reg != 16'hffff) tch_cnt_reg <= tch_cnt_reg + 16'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Repetition counts assume the filter length of 4 used on the bench
    sequence s_short_low;
        $fell(panel_reset_n) ##0 (!panel_reset_n)[*3] ##1 panel_reset_n;
    endsequence
    sequence s_short_high;
        (!panel_reset_n)[*4] ##1 panel_reset_n[*2] ##1 !panel_reset_n;
    endsequence
    a_glitch_low: assert property (s_short_low |=> (!$rose(blank_reg))[*6])
        else $error("short low pulse started a reset");
    a_spike_high: assert property (s_short_high |=> (!$rose(otp_load_reg))[*6])
        else $error("short high spike ended a reset");
    a_load_len: assert property ($fell(otp_load_reg) && panel_reset_n |-> otp_cnt_reg == LOAD_CYC)
        else $error("load length wrong");
    a_ready_after: assert property ($fell(otp_load_reg) && panel_reset_n |-> ##[0:1] cmd_ready_reg)
        else $error("command ready missing after load");
    a_load_blank: assert property (otp_load_reg |-> blank_reg && !cmd_ready_reg)
        else $error("not blanked or ready during load");
    a_seq_bound: assert property (blank_seq_reg |-> blank_reg && seq_cnt_reg < BLANK_CYC)
        else $error("blanking sequence too long");
    a_cfg_default: assert property ($rose(blank_reg) |-> ##[0:2] config_default_reg)
        else $error("config not defaulted on reset");
    a_wake_late: assert property ($rose(wake_ready_reg) |-> $past(cmd_ready_reg, 30))
        else $error("wake ready too early");
    a_touch_boot: assert property ($rose(touch_loader_active_reg) |-> tch_cnt_reg <= TOUCH_LOADER_CYC + 8)
        else $error("touch loader late");
    a_touch_done: assert property ($rose(touch_ready_reg) |-> tch_cnt_reg <= TOUCH_REBOOT_CYC + 8)
        else $error("touch reboot late");
endmodule // prs_sequencer_sva

bind prs_sequencer prs_sequencer_sva #(.LOAD_CYC(LOAD_CYC), .BLANK_CYC(BLANK_CYC),
    .TOUCH_LOADER_CYC(TOUCH_LOADER_CYC), .TOUCH_REBOOT_CYC(TOUCH_REBOOT_CYC)) u_prs_sequencer_sva (
    .core_clk(core_clk), .srst(srst), .panel_reset_n(panel_reset_n),
    .touch_reset_n(touch_reset_n), .blank_reg(blank_reg), .blank_seq_reg(blank_seq_reg),
    .config_default_reg(config_default_reg), .otp_load_reg(otp_load_reg),
    .cmd_ready_reg(cmd_ready_reg), .wake_ready_reg(wake_ready_reg),
    .touch_loader_active_reg(touch_loader_active_reg), .touch_ready_reg(touch_ready_reg));

//--- sim/prs_host_model.sv
// Host model driving the panel and touch reset lines
`timescale 1ns/1ps
module prs_host_model (
    input  wire logic core_clk,
    output logic      panel_reset_n,
    output logic      touch_reset_n
);
    // ==========
    // Line drivers, changed on the falling edge only
    initial panel_reset_n = 1'b1;
    initial touch_reset_n = 1'b1;
    // Callers hold valid lows past the glitch time but short of PULSE_MIN_CYC, inside the uncertain band
    task automatic drive_panel(input logic v);
        @(negedge core_clk);
        panel_reset_n = v;
    endtask
    task automatic drive_touch(input logic v);
        @(negedge core_clk);
        touch_reset_n = v;
    endtask
endmodule // prs_host_model

//--- sim/test_panel_reset_sequencer.sv
// Self-checking testbench for the panel reset sequencer
`timescale 1ns/1ps
module test_panel_reset_sequencer;
    localparam int LOAD = 20;
    localparam int WAKE = 60;
    logic core_clk;
    logic srst;
    logic awake;
    logic panel_reset_n;
    logic touch_reset_n;
    logic blank_reg;
    logic blank_seq_reg;
    logic config_default_reg;
    logic otp_load_reg;
    logic cmd_ready_reg;
    logic wake_ready_reg;
    logic touch_loader_active_reg;
    logic touch_ready_reg;
    int   error_cnt = 0;
    int   check_count = 0;
    // ==========
    // Instances
    // The glitch, load, wake and touch boot counts are shortened; blanking and the touch pulse minimum keep their real values
    prs_sequencer #(.GLITCH_CYC(4), .LOAD_CYC(LOAD), .WAKE_CYC(WAKE),
        .TOUCH_LOADER_CYC(30), .TOUCH_REBOOT_CYC(40))
        u_prs_sequencer (.core_clk(core_clk), .srst(srst), .panel_reset_n(panel_reset_n),
        .touch_reset_n(touch_reset_n), .awake(awake), .blank_reg(blank_reg),
        .blank_seq_reg(blank_seq_reg), .config_default_reg(config_default_reg),
        .otp_load_reg(otp_load_reg), .cmd_ready_reg(cmd_ready_reg),
        .wake_ready_reg(wake_ready_reg), .touch_loader_active_reg(touch_loader_active_reg),
        .touch_ready_reg(touch_ready_reg));
    prs_host_model u_prs_host_model (.core_clk(core_clk), .panel_reset_n(panel_reset_n),
        .touch_reset_n(touch_reset_n));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ==========
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Release the panel line and follow load and wake-up timing
    task automatic release_panel();
        int n;
        int k;
        n = 0;
        k = 0;
        u_prs_host_model.drive_panel(1'b1);
        while (wake_ready_reg !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
            if (otp_load_reg === 1'b1) k++;
        end
        chk(k, LOAD);
        chk(n >= WAKE && n <= WAKE + 8, 1);
        chk(cmd_ready_reg, 1);
        chk({blank_reg, config_default_reg}, 0);
    endtask
    // ==========
    // Scenarios
    task automatic t_panel(input logic a);
        awake = a;
        u_prs_host_model.drive_panel(1'b0);
        cyc(8);
        chk({blank_reg, blank_seq_reg, config_default_reg}, {1'b1, a, 1'b1});
        cyc(6);
        release_panel();
        $display("panel reset awake=%0d done", a);
    endtask
    task automatic t_glitch();
        u_prs_host_model.drive_panel(1'b0);
        cyc(2);
        u_prs_host_model.drive_panel(1'b1);
        cyc(8);
        chk({blank_reg, cmd_ready_reg}, 1);
        $display("glitch done");
    endtask
    task automatic t_spike();
        u_prs_host_model.drive_panel(1'b0);
        cyc(13);
        u_prs_host_model.drive_panel(1'b1);
        cyc(1);
        u_prs_host_model.drive_panel(1'b0);
        cyc(6);
        chk({blank_reg, otp_load_reg}, 2);
        cyc(8);
        release_panel();
        $display("spike done");
    endtask
    // A valid reset during the load restarts it without a new blanking run
    task automatic t_reload();
        awake = 1'b1;
        u_prs_host_model.drive_panel(1'b0);
        cyc(8);
        u_prs_host_model.drive_panel(1'b1);
        cyc(6);
        chk(otp_load_reg, 1);
        u_prs_host_model.drive_panel(1'b0);
        cyc(6);
        chk({blank_reg, blank_seq_reg, config_default_reg, otp_load_reg}, 4'ha);
        cyc(6);
        release_panel();
        $display("reload done");
    endtask
    task automatic t_touch();
        int n;
        int lo;
        n = 0;
        lo = -1;
        u_prs_host_model.drive_touch(1'b0);
        cyc(2);
        u_prs_host_model.drive_touch(1'b1);
        cyc(4);
        chk(touch_ready_reg, 1);
        u_prs_host_model.drive_touch(1'b0);
        cyc(6);
        chk(touch_ready_reg, 0);
        u_prs_host_model.drive_touch(1'b1);
        while (touch_ready_reg !== 1'b1 && n < 80) begin
            cyc(1);
            n++;
            if (lo < 0 && touch_loader_active_reg === 1'b1) lo = n;
        end
        chk(lo >= 0 && lo <= 38 && n <= 48 && n >= lo, 1);
        $display("touch done");
    endtask
    initial begin
        #400000;
        error_cnt++;
        summarize();
    end
    initial begin
        srst = 1'b1;
        awake = 1'b0;
        cyc(6);
        srst = 1'b0;
        cyc(2);
        chk({blank_reg, config_default_reg, otp_load_reg, cmd_ready_reg}, 4'h5);
        chk(touch_ready_reg, 1);
        $display("reset done");
        t_panel(1'b1);
        t_panel(1'b0);
        t_glitch();
        t_spike();
        t_reload();
        t_touch();
        summarize();
    end
endmodule // test_panel_reset_sequencer
